// ==== rtl/asr_consts.vh ====
// Purpose: constants for the static memory controller
// Assumes: 40 MHz clock, 25 ns period
// Notes:   times in ns, counts derived by rounding up
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
// ==========================================
// clock and memory timing
`define ASR_CLK_NS      25
`define ASR_T_ACC_NS    45
`define ASR_T_WP_NS     30
`define ASR_T_SD_NS     15
`define ASR_T_REC_NS    5
`define ASR_ACC_CYC     ((`ASR_T_ACC_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_WP_CYC      ((`ASR_T_WP_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_REC_CYC     ((`ASR_T_REC_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
// ==========================================
// array geometry and phase counter width
`define ASR_ADDR_W      16
`define ASR_CNT_W       4
// ==========================================
// synchroniser latency and reset values
`define ASR_SYNC_CYC    4'h4
`define ASR_ADDR_RST    16'h0000
`endif

// ==== rtl/asr_sync.v ====
// Purpose: three-stage synchroniser for the memory's data output pin
// Assumes: one clock domain
// Notes:   a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module asr_sync (
  // clock and reset
  input  wire CLK,
  input  wire RST_B,
  // pin and result
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge CLK) begin
    if (!RST_B) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/asr_ctrl.v ====
// Purpose: controller driving a 64k x 1 asynchronous static memory
// Assumes: one request at a time; REQ_READY shows when one is taken, except a chained read
// Notes:   write ends by raising both enables together; data held after
`timescale 1ns/10ps
`default_nettype none
`include "asr_consts.vh"
// ==========================================
// Notes on behaviour
// RULE_01: a write happens only while both enables are low and ends when either rises.
// RULE_02: data setup and hold are timed against the enable edge that ends the write.
// RULE_03: with chip enable high the memory is deselected and its output floats.
// RULE_04: chip enable low with write enable high reads the addressed bit.
// RULE_05: both enables low makes the memory take the data input pin level.
// RULE_06: if both enables rise together the output stays floating.
// RULE_07: address pins map 0-4 to row 3-7, 5-12 to columns 7,6,2,3,1,0,4,5, 13-15 to row 0-2.
// RULE_08: reads may keep chip enable low, the output following each address change.
// RULE_09: write enable stays high for the whole of each read.
// RULE_10: the address is valid before or as chip enable falls for a read.
// RULE_11: the memory holds 65,536 one-bit words with separate data in and out pins.
// RULE_12: the output floats whenever write enable is low.
// RULE_13: the stored value is the input level at the rising edge ending the write.
module asr_ctrl #(
  parameter ACC_CYC = `ASR_ACC_CYC,
  parameter WP_CYC  = `ASR_WP_CYC,
  parameter REC_CYC = `ASR_REC_CYC
) (
  // clock and reset
  input  wire                   CLK,
  input  wire                   RST_B,
  // user request
  input  wire                   REQ_VALID,
  input  wire                   REQ_WRITE,
  input  wire [`ASR_ADDR_W-1:0] REQ_ADDR,
  input  wire                   REQ_WDATA,
  output reg                    REQ_READY,
  // user answer
  output reg                    RD_VALID,
  output reg                    RD_DATA,
  // memory pins
  output reg  [`ASR_ADDR_W-1:0] MEM_ADDR,
  output reg                    MEM_CE_B,
  output reg                    MEM_WE_B,
  output reg                    MEM_DATA_IN_PIN,
  input  wire                   MEM_DATA_OUT,
  input  wire                   MEM_DATA_OUT_OE
);
  // ==========================================
  // states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD   = 3'h1;
  localparam [2:0] ST_WR   = 3'h2;
  localparam [2:0] ST_REC  = 3'h3;
  localparam [2:0] ST_WSET = 3'h4;

  // ==========================================
  // helper functions
  // counts are small; the low bits are kept on purpose
  function [`ASR_CNT_W-1:0] to_cnt;
    input integer val;
    begin
      to_cnt = val[`ASR_CNT_W-1:0];
    end
  endfunction

  // true in the last cycle of a phase that lasts len cycles
  function last_cyc;
    input [`ASR_CNT_W-1:0] cnt;
    input [`ASR_CNT_W-1:0] len;
    begin
      last_cyc = (cnt == len - 4'h1);
    end
  endfunction

  // ==========================================
  // phase lengths
  // the data output pin passes the synchroniser before it is read,
  // so a read waits for access time plus synchroniser latency
  localparam [`ASR_CNT_W-1:0] SYNC_LEN = `ASR_SYNC_CYC;
  localparam [`ASR_CNT_W-1:0] ACC_LEN  = to_cnt(ACC_CYC);
  localparam [`ASR_CNT_W-1:0] WP_LEN   = to_cnt(WP_CYC);
  localparam [`ASR_CNT_W-1:0] REC_LEN  = to_cnt(REC_CYC);
  localparam [`ASR_CNT_W-1:0] RD_LEN   = ACC_LEN + SYNC_LEN;

  // ==========================================
  // state and next values
  reg [2:0]             state_reg;
  reg [2:0]             state_next;
  reg [`ASR_CNT_W-1:0]  cnt_reg;
  reg [`ASR_CNT_W-1:0]  cnt_next;
  reg                   ready_next;
  reg                   rd_valid_next;
  reg                   rd_data_next;
  reg [`ASR_ADDR_W-1:0] addr_next;
  reg                   ce_b_next;
  reg                   we_b_next;
  reg                   din_next;
  wire                  dout_sync;
  wire                  take_idle;
  wire                  rd_last;
  wire                  take_chain;

  // ==========================================
  // data output pin synchroniser
  // MEM_DATA_OUT_OE is only informative; a floating pin reads as don't care
  asr_sync u_sync (
    .CLK   (CLK),
    .RST_B (RST_B),
    .din   (MEM_DATA_OUT),
    .dout  (dout_sync)
  );

  // ==========================================
  // request acceptance
  // a request is taken in idle with ready shown, or chained onto the
  // last cycle of a read; a pending write waits for idle instead
  assign take_idle  = REQ_VALID && REQ_READY && (state_reg == ST_IDLE);
  assign rd_last    = (state_reg == ST_RD) && last_cyc(cnt_reg, RD_LEN);
  assign take_chain = rd_last && REQ_VALID && !REQ_WRITE;

  // ==========================================
  // next-state logic
  always @* begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    ready_next    = 1'b0;
    rd_valid_next = 1'b0;
    rd_data_next  = RD_DATA;
    addr_next     = MEM_ADDR;
    ce_b_next     = MEM_CE_B;
    we_b_next     = MEM_WE_B;
    din_next      = MEM_DATA_IN_PIN;
    case (state_reg)
      ST_IDLE: begin
        ready_next = 1'b1;
        if (take_idle) begin
          ready_next = 1'b0;
          // address goes out with chip enable for a read, one cycle ahead of it for a write, see RULE_10
          addr_next  = REQ_ADDR;
          cnt_next   = 4'h0;
          if (REQ_WRITE) begin
            // address and data settle one cycle before the write opens
            din_next   = REQ_WDATA;
            state_next = ST_WSET;
          end else begin
            // read: chip enable low, write enable held high, see RULE_04
            ce_b_next  = 1'b0;
            we_b_next  = 1'b1; // see RULE_09
            state_next = ST_RD;
          end
        end
      end
      ST_WSET: begin
        // both enables low opens the write, see RULE_01 and RULE_05
        ce_b_next  = 1'b0;
        we_b_next  = 1'b0;
        state_next = ST_WR;
      end
      ST_WR: begin
        if (last_cyc(cnt_reg, WP_LEN)) begin
          // both rise together so the output never drives, see RULE_06
          // data held stable across the ending edge, see RULE_02
          ce_b_next  = 1'b1;
          we_b_next  = 1'b1;
          cnt_next   = 4'h0;
          state_next = ST_REC;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      ST_RD: begin
        if (rd_last) begin
          rd_data_next  = dout_sync;
          rd_valid_next = 1'b1;
          cnt_next      = 4'h0;
          if (take_chain) begin
            // back-to-back read keeps chip enable low, see RULE_08
            addr_next = REQ_ADDR;
          end else begin
            // deselect floats the output, see RULE_03
            ce_b_next  = 1'b1;
            state_next = ST_REC;
          end
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      ST_REC: begin
        // hold address and data through recovery, see RULE_13
        if (last_cyc(cnt_reg, REC_LEN)) begin
          cnt_next   = 4'h0;
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        ce_b_next  = 1'b1;
        we_b_next  = 1'b1;
      end
    endcase
  end

  // ==========================================
  // registers; every output leaves straight from a flip-flop
  always @(posedge CLK) begin
    if (!RST_B) begin
      state_reg       <= ST_IDLE;
      cnt_reg         <= 4'h0;
      REQ_READY       <= 1'b0;
      RD_VALID        <= 1'b0;
      RD_DATA         <= 1'b0;
      MEM_ADDR        <= `ASR_ADDR_RST;
      MEM_CE_B        <= 1'b1;
      MEM_WE_B        <= 1'b1;
      MEM_DATA_IN_PIN <= 1'b0;
    end else begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      REQ_READY       <= ready_next;
      RD_VALID        <= rd_valid_next;
      RD_DATA         <= rd_data_next;
      MEM_ADDR        <= addr_next;
      MEM_CE_B        <= ce_b_next;
      MEM_WE_B        <= we_b_next;
      MEM_DATA_IN_PIN <= din_next;
    end
  end
endmodule
`default_nettype wire

// ==== tb/asr_mem_model.sv ====
// Purpose: behavioural 64k x 1 static memory
// Assumes: no clock; the enables pick the mode
// Notes:   released output shows the stored bit inverted
`timescale 1ns/10ps
`default_nettype none
module asr_mem_model #(parameter int ACC_NS = 45) (
  // memory pins
  input  wire logic [15:0] addr,
  input  wire logic        ce_b,
  input  wire logic        we_b,
  input  wire logic        din,
  output wire logic        dout,
  output wire logic        oe
);
  // ========
  // array
  logic mem [0:65535];
  wire [15:0] loc = {addr[4:0], addr[15:13], addr[5], addr[6], addr[12],
    addr[11], addr[8], addr[7], addr[9], addr[10]};
  wire wr = !ce_b && !we_b;
  assign oe = !ce_b && we_b;
  // slow access; the delay also swallows a blip when both enables rise
  assign #(ACC_NS) dout = oe ~^ mem[loc];
  always @(negedge wr) mem[loc] = din;
endmodule
`default_nettype wire

// ==== tb/asr_ctrl_monitor.sv ====
// Purpose: pin checks on the memory controller
// Assumes: bound to the controller, one clock
// Notes:   chained reads keep chip enable low
`timescale 1ns/10ps
`default_nettype none
module asr_ctrl_chk (
  // clock, reset, user side
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic [15:0] REQ_ADDR,
  input wire logic        RD_VALID,
  // memory pins
  input wire logic [15:0] MEM_ADDR,
  input wire logic        MEM_CE_B,
  input wire logic        MEM_WE_B,
  input wire logic        MEM_DATA_IN_PIN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ========
  // properties
  chk_wr_pulse_end: assert property ($fell(MEM_WE_B) |->
    !MEM_WE_B [*2] ##1 (MEM_WE_B && MEM_CE_B)) else $error("write pulse");
  chk_wr_data_hold: assert property (!MEM_WE_B |=>
    $stable(MEM_DATA_IN_PIN) && $stable(MEM_ADDR)) else $error("write hold");
  chk_rd_we_high: assert property (!MEM_CE_B && MEM_WE_B |=>
    MEM_WE_B) else $error("write enable fell in read");
  chk_rd_addr_set: assert property ($fell(MEM_CE_B) && MEM_WE_B |->
    MEM_ADDR == $past(REQ_ADDR)) else $error("read address");
  chk_rd_answer: assert property ($fell(MEM_CE_B) && MEM_WE_B |->
    !MEM_CE_B [*6] ##1 RD_VALID) else $error("read answer");
  cover property ($fell(MEM_WE_B));
  cover property (RD_VALID);
  cover property (RD_VALID && !MEM_CE_B);
endmodule
bind asr_ctrl asr_ctrl_chk chk (.CLK(CLK), .RST_B(RST_B),
  .REQ_ADDR(REQ_ADDR), .RD_VALID(RD_VALID), .MEM_ADDR(MEM_ADDR),
  .MEM_CE_B(MEM_CE_B), .MEM_WE_B(MEM_WE_B),
  .MEM_DATA_IN_PIN(MEM_DATA_IN_PIN));
`default_nettype wire

// ==== tb/tb_async_sram_64k_by_1.sv ====
// Purpose: self-checking bench for the memory controller
// Assumes: behavioural memory behind the pins
// Notes:   memory contents outlive a controller reset
`timescale 1ns/10ps
`default_nettype none
module tb_async_sram_64k_by_1;
  // ========
  // wiring
  logic clk = 0, rst_b = 0, req_valid = 0, req_write = 0, req_wdata = 0, q;
  logic [15:0] req_addr = 16'h0000;
  wire ready, rd_valid, rd_data, ce_b, we_b, din, dout, oe;
  wire [15:0] addr;
  int bad_count = 0, checks = 0;
  // write flag, data or expected bit, address
  logic [17:0] rows [10] = '{18'h30001, 18'h2ffff, 18'h38000, 18'h20020,
    18'h10001, 18'h0ffff, 18'h18000, 18'h00020, 18'h3ffff, 18'h1ffff};
  always #12.5 clk = ~clk;
  asr_ctrl dut (.CLK(clk), .RST_B(rst_b), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_READY(ready), .RD_VALID(rd_valid), .RD_DATA(rd_data),
    .MEM_ADDR(addr), .MEM_CE_B(ce_b), .MEM_WE_B(we_b),
    .MEM_DATA_IN_PIN(din), .MEM_DATA_OUT(dout), .MEM_DATA_OUT_OE(oe));
  asr_mem_model mem (.addr(addr), .ce_b(ce_b), .we_b(we_b), .din(din),
    .dout(dout), .oe(oe));
  task automatic chk(input string what, input logic seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic get;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 40);
    q = rd_data;
    if (rd_valid !== 1'b1) bad_count++;
  endtask
  // request held until taken; a different next address chains a read
  task automatic op(input logic [17:0] r, input logic [15:0] nxt);
    int n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    {req_write, req_wdata, req_addr} <= r;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 40);
    if (ready !== 1'b1) bad_count++;
    if (nxt != r[15:0]) req_addr <= nxt;
    else req_valid <= 1'b0;
    if (!r[17]) get;
    if (!r[17] && nxt == r[15:0]) chk("read bit", q, r[16]);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    // about eight times the expected run
    #20us;
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) op(rows[i], rows[i][15:0]);
    op(18'h10001, 16'h0020);
    chk("first chained bit", q, 1'b1);
    chk("chip enable", ce_b, 1'b0);
    req_valid <= 1'b0;
    get;
    chk("second chained bit", q, 1'b0);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("enables in reset", ce_b & we_b, 1'b1);
    rst_b <= 1'b1;
    op(18'h1ffff, 16'hffff);
    wrap_up;
  end
endmodule
`default_nettype wire
